/* File: src/wdtc_pkg.sv */
`default_nettype none
package wdtc_pkg;
   // bus geometry
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 32;
   // register byte addresses
   localparam logic [AW-1:0] OFF_CTRL    = 8'h00;
   localparam logic [AW-1:0] OFF_CAUSE   = 8'h04;
   localparam logic [AW-1:0] OFF_IRQ_ST  = 8'h08;
   localparam logic [AW-1:0] OFF_IRQ_MSK = 8'h0c;
   localparam logic [AW-1:0] OFF_RESTART = 8'h10;
   // control and cause field positions
   localparam int unsigned BIT_UNLOCK = 4;
   localparam int unsigned BIT_ON     = 3;
   localparam int unsigned BIT_FLAG   = 3;
   // interrupt status bits
   localparam int unsigned IRQ_TIMEOUT = 0;
   localparam int unsigned IRQ_REFUSED = 1;
   localparam int unsigned IRQ_W       = 2;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // timing: oscillator derived from the bus clock by a divider
   localparam int unsigned SYS_CLK_HZ = 50_000_000;
   localparam int unsigned OSC_HZ     = 1_000_000;
   localparam int unsigned TICK_DIV   = SYS_CLK_HZ / OSC_HZ;
   localparam int unsigned DIV_W      = 6;
   localparam int unsigned UNLOCK_CYCLES = 4;
   localparam logic [2:0]  UNLOCK_LOAD   = 3'h4;
   localparam logic [2:0]  UNLOCK_LAST   = 3'h1;
   // timeout counts in oscillator cycles, code 0 and width for code 7
   localparam int unsigned BASE_OSC_CYCLES = 16_384;
   localparam int unsigned CNT_W           = 22;

   typedef struct packed
   {
      logic [2:0] rsv;
      logic       unlock;
      logic       on;
      logic [2:0] sel;
   } wdtc_ctrl_t;
endpackage
`default_nettype wire

/* File: src/wdtc_top.sv */
// Our own choices: register access over APB and the address map.
`default_nettype none
module wdtc_top #(
   parameter int unsigned BASE_CYCLES = wdtc_pkg::BASE_OSC_CYCLES
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [wdtc_pkg::AW-1:0] paddr,
   input  wire logic [wdtc_pkg::DW-1:0] pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [wdtc_pkg::DW-1:0] prdata,
   output logic                         pready,
   output logic                         pslverr,
   output logic                         chip_reset,
   output logic                         irq
);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wdtc_pkg::wdtc_ctrl_t             ctrl_q;
   logic [wdtc_pkg::DW-1:0]          prdata_q;
   logic                             pready_q;
   logic                             pslverr_q;
   logic [2:0]                       unlock_cnt_q;
   logic                             flag_q;
   logic [wdtc_pkg::IRQ_W-1:0]       irq_st_q;
   logic [wdtc_pkg::IRQ_W-1:0]       irq_msk_q;
   logic                             irq_q;
   logic                             chip_reset_q;
   logic [wdtc_pkg::DIV_W-1:0]       div_q;
   logic                             tick_q;
   logic [wdtc_pkg::CNT_W-1:0]       cnt_q;
   logic [wdtc_pkg::CNT_W-1:0]       limit;
   logic                             mapped;
   logic                             wr_en;
   logic                             wr_ctrl;
   logic                             wr_unlock;
   logic                             refused;
   logic                             restart;
   logic                             expire;
   logic [wdtc_pkg::DW-1:0]          rd_mux;

   // write commits only at the access edge that sees pready
   assign wr_en     = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];
   assign wr_ctrl   = wr_en && (paddr == wdtc_pkg::OFF_CTRL);
   assign wr_unlock = wr_ctrl && pwdata[wdtc_pkg::BIT_UNLOCK];
   assign refused   = wr_ctrl && !pwdata[wdtc_pkg::BIT_ON] && ctrl_q.on && !ctrl_q.unlock;
   assign restart   = wr_en && (paddr == wdtc_pkg::OFF_RESTART);
   assign mapped    = (paddr == wdtc_pkg::OFF_CTRL) || (paddr == wdtc_pkg::OFF_CAUSE) ||
                      (paddr == wdtc_pkg::OFF_IRQ_ST) || (paddr == wdtc_pkg::OFF_IRQ_MSK) ||
                      (paddr == wdtc_pkg::OFF_RESTART);

   // read mux; restart reads as zero
   always_comb
   begin
      rd_mux = '0;
      case (paddr)
         wdtc_pkg::OFF_CTRL:    rd_mux[7:0] = {3'h0, ctrl_q.unlock, ctrl_q.on, ctrl_q.sel};
         wdtc_pkg::OFF_CAUSE:   rd_mux[wdtc_pkg::BIT_FLAG] = flag_q;
         wdtc_pkg::OFF_IRQ_ST:  rd_mux[wdtc_pkg::IRQ_W-1:0] = irq_st_q;
         wdtc_pkg::OFF_IRQ_MSK: rd_mux[wdtc_pkg::IRQ_W-1:0] = irq_msk_q;
         default:               rd_mux = '0;
      endcase
   end

   // one wait-free answer: data and error latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= psel && !penable;
         if (psel && !penable)
         begin
            prdata_q  <= rd_mux;
            pslverr_q <= !mapped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register

   // reserved bits are never stored, so they cannot leak into a read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= wdtc_pkg::CTRL_RESET;
      end
      else
      begin
         ctrl_q.rsv <= 3'h0;
         if (wr_ctrl)
         begin
            ctrl_q.sel <= pwdata[2:0];
            if (pwdata[wdtc_pkg::BIT_ON])
            begin
               ctrl_q.on <= 1'b1;
            end
            else if (ctrl_q.unlock)
            begin
               ctrl_q.on <= 1'b0;
            end
         end
         if (wr_unlock)
         begin
            ctrl_q.unlock <= 1'b1;
         end
         else if (ctrl_q.unlock && unlock_cnt_q == wdtc_pkg::UNLOCK_LAST)
         begin
            ctrl_q.unlock <= 1'b0;
         end
      end
   end

   // window counter in bus cycles; a new unlocking write reloads it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unlock_cnt_q <= 3'h0;
      end
      else if (wr_unlock)
      begin
         unlock_cnt_q <= wdtc_pkg::UNLOCK_LOAD;
      end
      else if (unlock_cnt_q != 3'h0)
      begin
         unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // oscillator tick and timeout counter

   // the oscillator is modelled as an enable from the single bus clock, so no
   // crossing logic is needed; a true second clock would need synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (div_q == wdtc_pkg::DIV_W'(wdtc_pkg::TICK_DIV - 1))
      begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end
      else
      begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   assign limit  = wdtc_pkg::CNT_W'(BASE_CYCLES) << ctrl_q.sel;
   assign expire = ctrl_q.on && tick_q && !restart && (cnt_q == limit - 1'b1);

   // count restarts on command, while off, and when it fires
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
      end
      else if (restart || !ctrl_q.on || expire)
      begin
         cnt_q <= '0;
      end
      else if (tick_q)
      begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // chip reset is a single-cycle pulse per expiry
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chip_reset_q <= 1'b0;
      end
      else
      begin
         chip_reset_q <= expire;
      end
   end

   // reset cause flag: an expiry in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= 1'b0;
      end
      else if (expire)
      begin
         flag_q <= 1'b1;
      end
      else if (wr_en && paddr == wdtc_pkg::OFF_CAUSE && !pwdata[wdtc_pkg::BIT_FLAG])
      begin
         flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky status, write one to clear, set wins

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_st_q  <= '0;
         irq_msk_q <= '0;
         irq_q     <= 1'b0;
      end
      else
      begin
         irq_st_q <= (irq_st_q & ~((wr_en && paddr == wdtc_pkg::OFF_IRQ_ST) ?
                      pwdata[wdtc_pkg::IRQ_W-1:0] : {wdtc_pkg::IRQ_W{1'b0}}))
                     | {refused, expire};
         if (wr_en && paddr == wdtc_pkg::OFF_IRQ_MSK)
         begin
            irq_msk_q <= pwdata[wdtc_pkg::IRQ_W-1:0];
         end
         irq_q <= |(irq_st_q & irq_msk_q);
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign chip_reset = chip_reset_q;
   assign irq        = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_rsv_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == wdtc_pkg::OFF_CTRL |=> prdata_q[7:5] == 3'h0)
      else $error("reserved control bits read nonzero");

   a_unlock_holds: assert property (@(posedge pclk) disable iff (!presetn)
      wr_unlock |=> ctrl_q.unlock[*4])
      else $error("unlock bit dropped early");

   a_unlock_clears: assert property (@(posedge pclk) disable iff (!presetn)
      wr_unlock ##1 (!wr_unlock)[*4] |=> !ctrl_q.unlock)
      else $error("unlock bit not cleared after four cycles");

   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl && pwdata[wdtc_pkg::BIT_ON] |=> ctrl_q.on)
      else $error("enable write did not start watchdog");

   a_guarded_off: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl && !pwdata[wdtc_pkg::BIT_ON] |=> ctrl_q.on == $past(ctrl_q.on && !ctrl_q.unlock))
      else $error("disable guard misbehaved");

   a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q |=> (!tick_q)[*8])
      else $error("oscillator ticks too close");

   a_off_restarts: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q.on |=> cnt_q == '0)
      else $error("count not held while disabled");

   a_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      expire |=> chip_reset_q ##1 !chip_reset_q)
      else $error("chip reset pulse not one cycle");

   a_cause_flag: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(chip_reset_q) |-> flag_q && irq_st_q[wdtc_pkg::IRQ_TIMEOUT])
      else $error("cause flag not set on expiry");

   a_limit_scale: assert property (@(posedge pclk) disable iff (!presetn)
      expire |-> int'(cnt_q) + 1 == int'(BASE_CYCLES) * (1 << ctrl_q.sel))
      else $error("expiry at wrong count");

endmodule
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned BASE = 4;
   localparam int unsigned TICK = 50;
   logic                         pclk;
   logic                         presetn;
   logic                         psel;
   logic                         penable;
   logic                         pwrite;
   logic [wdtc_pkg::AW-1:0]      paddr;
   logic [wdtc_pkg::DW-1:0]      pwdata;
   logic [3:0]                   pstrb;
   logic [wdtc_pkg::DW-1:0]      prdata;
   logic                         pready;
   logic                         pslverr;
   logic                         chip_reset;
   logic                         irq;
   logic [31:0]                  rd;
   logic                         er;
   int                           errors;
   int                           n_tests;
   int                           c;
   int                           n;
   int                           seen;

   // short base count keeps the longest timeout near 26k clocks
   wdtc_top #(.BASE_CYCLES(BASE)) wdtc_top_i (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .pstrb      (pstrb),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .chip_reset (chip_reset),
      .irq        (irq)
   );

   ////////////////////////////////////////////////////////////////
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic give_verdict;
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         errors++;
         give_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hf);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      xfer(1'b0, a, 32'h0, 4'h0);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, experr});
   endtask

   // idle cycles while counting any reset pulse
   task automatic idle(input int cyc);
      repeat (cyc)
      begin
         @(posedge pclk);
         if (chip_reset !== 1'b0)
            seen++;
      end
   endtask

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      errors = 0;
      n_tests = 0;
      seen = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h00, 1'b0);
      rd_chk(wdtc_pkg::OFF_CAUSE, 32'h00, 1'b0);
      wr(wdtc_pkg::OFF_IRQ_MSK, 32'h3);
      wr(wdtc_pkg::OFF_CTRL, 32'hffff_ffe9);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h09, 1'b0);
      // disable without unlock is refused and flagged; select kept at 1 since it is writable any time
      wr(wdtc_pkg::OFF_CTRL, 32'h01);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h09, 1'b0);
      rd_chk(wdtc_pkg::OFF_IRQ_ST, 32'h02, 1'b0);
      chk({31'h0, irq}, 32'h1);
      wr(wdtc_pkg::OFF_IRQ_ST, 32'h2);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, wdtc_pkg::OFF_CTRL, 32'h0b, 4'he);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h09, 1'b0);
      // unlock then let the window lapse before the disable write
      wr(wdtc_pkg::OFF_CTRL, 32'h19);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h19, 1'b0);
      idle(4);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h09, 1'b0);
      wr(wdtc_pkg::OFF_CTRL, 32'h01);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h09, 1'b0);
      // unlock and disable back to back, inside the window
      wr(wdtc_pkg::OFF_CTRL, 32'h19);
      wr(wdtc_pkg::OFF_CTRL, 32'h01);
      rd_chk(wdtc_pkg::OFF_CTRL, 32'h01, 1'b0);
      idle(1000);
      chk(seen, 0);
      rd_chk(8'h20, 32'h0, 1'b1);
      xfer(1'b1, 8'h20, 32'hff, 4'hf);
      chk({31'h0, er}, 32'h1);
      // periodic restarts keep the shortest period from expiring
      wr(wdtc_pkg::OFF_CTRL, 32'h08);
      repeat (6)
      begin
         idle(100);
         wr(wdtc_pkg::OFF_RESTART, 32'h0);
      end
      chk(seen, 0);
      wr(wdtc_pkg::OFF_IRQ_ST, 32'h3);
      // every select code: expiry time, pulse width, cause and irq
      for (int k = 0; k < 8; k++)
      begin
         n = BASE << k;
         wr(wdtc_pkg::OFF_CTRL, 32'h08 | k);
         wr(wdtc_pkg::OFF_RESTART, 32'h0);
         c = 0;
         do
         begin
            @(posedge pclk);
            c++;
         end
         while (chip_reset !== 1'b1 && c < n * TICK + 10);
         chk(c > (n - 1) * TICK && c <= n * TICK + 3, 32'h1);
         if (c >= n * TICK + 10)
            give_verdict();
         @(posedge pclk);
         chk({31'h0, chip_reset}, 32'h0);
         rd_chk(wdtc_pkg::OFF_CAUSE, 32'h08, 1'b0);
         rd_chk(wdtc_pkg::OFF_IRQ_ST, 32'h01, 1'b0);
         chk({31'h0, irq}, 32'h1);
         wr(wdtc_pkg::OFF_CAUSE, 32'h0);
         rd_chk(wdtc_pkg::OFF_CAUSE, 32'h00, 1'b0);
         if (k < 7)
            wr(wdtc_pkg::OFF_IRQ_ST, 32'h1);
      end
      // masking hides a pending status bit, clearing drops it
      wr(wdtc_pkg::OFF_IRQ_MSK, 32'h0);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      wr(wdtc_pkg::OFF_IRQ_ST, 32'h1);
      wr(wdtc_pkg::OFF_IRQ_MSK, 32'h3);
      rd_chk(wdtc_pkg::OFF_IRQ_ST, 32'h00, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
